// File: rtl/smfs_pkg.sv
// package for the switch mode and fault supervisor
// assumes a 25 MHz core clock; times are converted to cycle counts here
package smfs_pkg;
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned WDOG_TIMEOUT_MS  = 310;
  localparam int unsigned INPUT_IDLE_MS    = 250;
  localparam int unsigned WDOG_TIMEOUT_CYC = (CLK_HZ / 1000) * WDOG_TIMEOUT_MS;
  localparam int unsigned INPUT_IDLE_CYC   = (CLK_HZ / 1000) * INPUT_IDLE_MS;

  // register indices
  localparam logic [3:0] REG_GLOBAL_CONFIG = 4'h0;
  localparam logic [3:0] REG_PULSE_WIDTH0  = 4'h1;
  localparam logic [3:0] REG_PULSE_WIDTH1  = 4'h2;
  localparam logic [3:0] REG_CHAN_CFG      = 4'h3;
  localparam logic [3:0] REG_GLOBAL_STATUS = 4'h4;
  localparam logic [3:0] REG_CHAN_FAULT0   = 4'h5;
  localparam logic [3:0] REG_CHAN_FAULT1   = 4'h6;

  // global config fields
  localparam int unsigned GCR_WDOG_DIS  = 4;
  localparam int unsigned GCR_OV_EN     = 3;
  localparam int unsigned GCR_SUPFAIL_EN = 2;
  localparam int unsigned GCR_PARALLEL  = 1;
  localparam int unsigned GCR_POR       = 0;
  localparam logic [15:0] GCR_RESET     = 16'h0008;
  // channel config: bit0 direct-input disable ch0, bit1 ch1, bits 4..7 detector enables
  localparam int unsigned CFG_DIR_DIS0  = 0;
  localparam int unsigned CFG_DIR_DIS1  = 1;
  localparam int unsigned CFG_OS_EN     = 4;
  localparam int unsigned CFG_OLOFF_EN  = 5;
  localparam int unsigned CFG_OLON_EN   = 6;
  localparam int unsigned CFG_CLKF_EN   = 7;
  localparam logic [15:0] CFG_RESET     = 16'h0080;
  localparam int unsigned PWR_ON_BIT    = 8;
  localparam int unsigned WORD_TOGGLE   = 15;
  // channel fault register bits
  localparam int unsigned FB_OC = 0;
  localparam int unsigned FB_SC = 1;
  localparam int unsigned FB_OT = 2;
  localparam int unsigned FB_OS = 3;
  localparam int unsigned FB_OLON = 4;
  localparam int unsigned FB_OLOFF = 5;
  localparam int unsigned FB_CLKF = 6;
  localparam int unsigned FB_LATCHED = 7;
  // global status bits
  localparam int unsigned SB_UV = 0;
  localparam int unsigned SB_OV = 1;
  localparam logic [7:0]  LATCHABLE_MASK = 8'h07;

  typedef enum logic [3:0] {
    MODE_SLEEP    = 4'b0001,
    MODE_NORMAL   = 4'b0010,
    MODE_FAILSAFE = 4'b0100,
    MODE_FAULT    = 4'b1000
  } smfs_mode_t;
endpackage

// File: rtl/smfs_top.sv
// switch mode and fault supervisor: mode selection, watchdog, sticky and latched faults
// assumes the serial word receiver, fault detectors and retry counter sit outside
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module smfs_top #(
  parameter int unsigned WDOG_CYC = smfs_pkg::WDOG_TIMEOUT_CYC,
  parameter int unsigned IDLE_CYC = smfs_pkg::INPUT_IDLE_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_wake_hold,
  input  wire logic [1:0]        i_direct_in,
  input  wire logic              i_vdd_ok,
  input  wire logic              i_word_valid,
  input  wire logic [15:0]       i_word,
  input  wire logic [1:0]        i_oc,
  input  wire logic [1:0]        i_ot,
  input  wire logic [1:0]        i_sc,
  input  wire logic [1:0]        i_os,
  input  wire logic [1:0]        i_ol_on,
  input  wire logic [1:0]        i_ol_off,
  input  wire logic [1:0]        i_clk_fail,
  input  wire logic              i_uv,
  input  wire logic              i_ov,
  input  wire logic [1:0]        i_retry_turn_on,
  input  wire logic [1:0]        i_retry_expired,
  input  wire logic [1:0]        i_retry_reset,
  input  wire logic              i_retry_en,
  input  wire logic              i_power_on,
  input  wire logic [3:0]        i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [15:0]       o_rdata,
  output logic      [1:0]        o_chan_on,
  output logic                   o_failsafe_n,
  output logic                   o_fault_status_n,
  output smfs_pkg::smfs_mode_t   o_mode
);
  import smfs_pkg::*;

  initial begin
    if (WDOG_CYC < 1 || IDLE_CYC < 1 || WDOG_CYC >= 32'hFFFF_FFFF) begin
      $error("smfs_top: bad cycle counts");
    end
  end

  // two-flop synchronisers for pin-domain inputs
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {i_wake_hold, i_direct_in};
      sync2 <= sync1;
    end
  end
  wire       hold   = sync2[2];
  wire [1:0] din    = sync2[1:0];
  logic      hold_d;

  // input activity flags
  logic [31:0] idle_cnt [2];
  logic [1:0]  act;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_act
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          idle_cnt[g] <= '0;
          act[g]      <= 1'b0;
        end else if (din[g]) begin
          idle_cnt[g] <= '0;
          act[g]      <= 1'b1;
        end else if (idle_cnt[g] >= IDLE_CYC) begin
          act[g]      <= 1'b0;
        end else begin
          idle_cnt[g] <= idle_cnt[g] + 32'h0000_0001;
        end
      end
    end
  endgenerate

  // registers
  logic [15:0] global_config_register;
  logic [15:0] cfg;
  logic [15:0] pwr [2];
  logic [7:0]  fault_bits [2];
  logic [1:0]  gstat;
  logic [1:0]  latched;
  smfs_mode_t  mode;

  wire watchdog_disable_bit  = global_config_register[GCR_WDOG_DIS];
  wire ov_en   = global_config_register[GCR_OV_EN];
  wire sup_en  = global_config_register[GCR_SUPFAIL_EN];

  // watchdog
  logic [31:0] wd_cnt;
  logic        wd_run;
  logic        wd_last;
  logic        wd_timeout;
  wire wd_active = i_vdd_ok && !watchdog_disable_bit && hold;
  wire hold_rise = hold && !hold_d;

  // fail-safe exit sequence
  logic        exit_armed;
  logic [31:0] exit_cnt;
  logic        fs_sticky;
  wire in_fs_any = (mode == MODE_FAILSAFE) || fs_sticky;

  wire wake     = hold | act[0] | act[1];
  wire fs_term  = (!i_vdd_ok && sup_en) || (wd_timeout && !watchdog_disable_bit);
  wire fault_term = (|i_oc) | (|i_ot) | (|i_sc) | i_uv | (i_ov & ov_en);
  wire fs_now   = fs_term || fs_sticky;

  smfs_mode_t next_mode;
  always_comb begin
    if (!wake)           next_mode = MODE_SLEEP;
    else if (fault_term) next_mode = MODE_FAULT;
    else if (fs_now)     next_mode = MODE_FAILSAFE;
    else                 next_mode = MODE_NORMAL;
  end

  wire fs_enter  = fs_term && !fs_sticky;
  wire exit_done = exit_armed && i_word_valid && exit_cnt < WDOG_CYC;
  wire reg_block = fs_sticky || mode == MODE_SLEEP;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode      <= MODE_SLEEP;
      hold_d    <= 1'b0;
      fs_sticky <= 1'b0;
    end else begin
      mode   <= next_mode;
      hold_d <= hold;
      if (fs_enter && wake) fs_sticky <= 1'b1;
      else if (exit_done)   fs_sticky <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_cnt     <= '0;
      wd_run     <= 1'b0;
      wd_last    <= 1'b0;
      wd_timeout <= 1'b0;
    end else if (!wd_active || fs_sticky) begin
      // a started timer survives a disable; leaving fail-safe restarts it
      wd_run     <= (wd_run && hold && !fs_sticky) || exit_done;
      wd_cnt     <= '0;
      wd_timeout <= 1'b0;
    end else if (hold_rise) begin
      wd_run <= 1'b1;
      wd_cnt <= '0;
    end else if (wd_run) begin
      if (i_word_valid && i_word[WORD_TOGGLE] != wd_last) begin
        wd_last <= i_word[WORD_TOGGLE];
        wd_cnt  <= '0;
      end else if (wd_cnt >= WDOG_CYC) begin
        wd_timeout <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      exit_armed <= 1'b0;
      exit_cnt   <= '0;
    end else if (!fs_sticky || exit_done) begin
      exit_armed <= 1'b0;
      exit_cnt   <= '0;
    end else if (!exit_armed) begin
      exit_cnt <= '0;
      if (i_word_valid && i_word[WORD_TOGGLE]) exit_armed <= 1'b1;
    end else if (exit_cnt >= WDOG_CYC) begin
      exit_armed <= 1'b0;
    end else begin
      exit_cnt <= exit_cnt + 32'h0000_0001;
    end
  end

  // fault control and delatch detection
  logic [1:0] fc;
  logic [1:0] fc_d;
  logic [1:0] fc_seen_low;
  wire  [1:0] dir_dis = {cfg[CFG_DIR_DIS1], cfg[CFG_DIR_DIS0]};
  wire  [1:0] on_bit  = {pwr[1][PWR_ON_BIT], pwr[0][PWR_ON_BIT]};
  assign fc = (act & ~dir_dis) | on_bit;

  wire [1:0] cause = i_oc | i_ot | i_sc | {2{i_uv}};
  wire [1:0] delatch_req;
  assign delatch_req = (fc_seen_low & fc & ~fc_d) | (i_retry_reset & {2{i_retry_en}});

  function automatic logic [7:0] chan_events(input logic [1:0] idx);
    logic [7:0] e;
    e = '0;
    e[FB_OC]    = i_oc[idx[0]];
    e[FB_SC]    = i_sc[idx[0]];
    e[FB_OT]    = i_ot[idx[0]];
    e[FB_OS]    = i_os[idx[0]] & cfg[CFG_OS_EN];
    e[FB_OLON]  = i_ol_on[idx[0]] & cfg[CFG_OLON_EN];
    e[FB_OLOFF] = i_ol_off[idx[0]] & cfg[CFG_OLOFF_EN];
    e[FB_CLKF]  = i_clk_fail[idx[0]] & cfg[CFG_CLKF_EN];
    return e;
  endfunction

  wire rd_f0 = i_rd && !reg_block && i_addr == REG_CHAN_FAULT0;
  wire rd_f1 = i_rd && !reg_block && i_addr == REG_CHAN_FAULT1;
  wire rd_st = i_rd && !reg_block && i_addr == REG_GLOBAL_STATUS;
  wire [1:0] rd_f = {rd_f1, rd_f0};
  wire to_normal = exit_done;

  generate
    for (g = 0; g < 2; g++) begin : g_flt
      wire [7:0] ev = chan_events(2'(g));
      wire [7:0] clr_mask = (rd_f[g] && !latched[g]) ? ev : 8'hFF;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          fault_bits[g]  <= '0;
          latched[g]     <= 1'b0;
          fc_d[g]        <= 1'b0;
          fc_seen_low[g] <= 1'b0;
        end else begin
          fc_d[g] <= fc[g];
          if (fc_d[g] && !fc[g]) fc_seen_low[g] <= 1'b1;
          else if (delatch_req[g]) fc_seen_low[g] <= 1'b0;
          if (i_power_on || (fs_enter && !fs_sticky)) begin
            latched[g] <= 1'b0;
          end else if (delatch_req[g] && !cause[g]) begin
            latched[g] <= 1'b0;
          end else if (i_retry_turn_on[g] && i_retry_expired[g] && cause[g]) begin
            latched[g] <= 1'b1;
          end
          if (i_power_on || fs_enter || to_normal) begin
            fault_bits[g] <= (to_normal && latched[g]) ? (fault_bits[g] & LATCHABLE_MASK) : 8'h00;
          end else begin
            // set wins over a read clear; latchable bits hold until a read while the channel is not latched
            fault_bits[g] <= ((fault_bits[g] & clr_mask)
                              | (fault_bits[g] & LATCHABLE_MASK & ~{8{i_retry_turn_on[g]}}
                                 & {8{!rd_f[g] || latched[g]}})
                              | ev) & 8'h7F;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gstat <= '0;
    end else begin
      gstat[SB_UV] <= i_uv | (gstat[SB_UV] & ~(rd_st & ~i_uv));
      gstat[SB_OV] <= i_ov | (gstat[SB_OV] & ~(rd_st & ~i_ov));
    end
  end

  // register writes; block while in fail-safe or sleep
  wire wr_ok = i_wr && !reg_block;
  wire reg_reset = fs_enter || to_normal || mode == MODE_SLEEP || i_power_on;
  wire [15:0] keep_gcr = global_config_register & ((16'h0001 << GCR_POR) | (16'h0001 << GCR_PARALLEL));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      global_config_register    <= GCR_RESET;
      cfg    <= CFG_RESET;
      pwr[0] <= '0;
      pwr[1] <= '0;
    end else if (reg_reset) begin
      global_config_register    <= GCR_RESET | keep_gcr;
      cfg    <= CFG_RESET;
      pwr[0] <= '0;
      pwr[1] <= '0;
    end else if (wr_ok) begin
      if (i_addr == REG_GLOBAL_CONFIG) global_config_register    <= i_wdata;
      if (i_addr == REG_CHAN_CFG)      cfg    <= i_wdata;
      if (i_addr == REG_PULSE_WIDTH0)  pwr[0] <= i_wdata;
      if (i_addr == REG_PULSE_WIDTH1)  pwr[1] <= i_wdata;
    end
  end

  // read data one cycle after the strobe
  logic [15:0] rsel;
  always_comb begin
    unique case (i_addr)
      REG_GLOBAL_CONFIG: rsel = global_config_register;
      REG_PULSE_WIDTH0:  rsel = pwr[0];
      REG_PULSE_WIDTH1:  rsel = pwr[1];
      REG_CHAN_CFG:      rsel = cfg;
      REG_GLOBAL_STATUS: rsel = {8'h00, 1'b0, fs_sticky, mode, gstat[SB_OV], gstat[SB_UV]};
      REG_CHAN_FAULT0:   rsel = {8'h00, latched[0], fault_bits[0][6:0]};
      REG_CHAN_FAULT1:   rsel = {8'h00, latched[1], fault_bits[1][6:0]};
      default:           rsel = 16'h0000;
    endcase
  end

  // outputs
  wire direct_ctl = !hold || fs_sticky;
  wire [1:0] serial_on = on_bit;
  wire [1:0] chan_off  = i_oc | i_ot | i_sc | latched | {2{i_uv | (i_ov & ov_en)}};
  wire [1:0] next_on   = (mode == MODE_SLEEP) ? 2'b00 :
                         ((direct_ctl ? din : serial_on) & ~chan_off);
  wire any_fault = fault_term | (|latched)
                   | (|(i_os & {2{cfg[CFG_OS_EN]}})) | (|(i_clk_fail & {2{cfg[CFG_CLKF_EN]}}))
                   | (|(i_ol_on & {2{cfg[CFG_OLON_EN]}})) | (|(i_ol_off & {2{cfg[CFG_OLOFF_EN]}}));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata          <= '0;
      o_chan_on        <= '0;
      o_failsafe_n     <= 1'b1;
      o_fault_status_n <= 1'b1;
      o_mode           <= MODE_SLEEP;
    end else begin
      o_rdata          <= (i_rd && !reg_block) ? rsel : 16'h0000;
      o_chan_on        <= next_on;
      o_failsafe_n     <= !(fs_sticky || (fs_enter && wake));
      o_fault_status_n <= !any_fault;
      o_mode           <= next_mode;
    end
  end

  wire unused_ok = in_fs_any;
endmodule // smfs_top

// File: verif/smfs_chk_sva.sv
// checker for the mode and fault supervisor, watching only top-level ports
// assumes reset is asynchronous active low and inputs settle through two sync flops
`timescale 1ns/1ps
module smfs_chk #(
  parameter int unsigned WDOG_CYC = 200,
  parameter int unsigned IDLE_CYC = 100
) (
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_wake_hold,
  input wire logic [1:0]           i_direct_in,
  input wire logic [1:0]           i_oc,
  input wire logic                 i_uv,
  input wire logic                 i_rd,
  input wire logic [15:0]          o_rdata,
  input wire logic [1:0]           o_chan_on,
  input wire logic                 o_failsafe_n,
  input wire logic                 o_fault_status_n,
  input wire smfs_pkg::smfs_mode_t o_mode
);
  import smfs_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // counts quiet cycles; margin below covers sync and mode register latency
  logic [31:0] idle_cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      idle_cnt <= 32'h0000_0000;
    else if (i_wake_hold || i_direct_in != 2'h0)
      idle_cnt <= 32'h0000_0000;
    else
      idle_cnt <= idle_cnt + 32'h0000_0001;
  end
  AST_SLEEP_OFF: assert property (o_mode == MODE_SLEEP |-> o_chan_on == 2'h0)
    else $error("channel on while sleeping");
  AST_WAKE: assert property (i_wake_hold [*6] |-> o_mode != MODE_SLEEP)
    else $error("asleep with wake hold high");
  AST_IDLE_SLEEP: assert property (idle_cnt == IDLE_CYC + 8 |-> o_mode == MODE_SLEEP)
    else $error("not asleep after idle time");
  AST_OC_FAULT: assert property ((i_oc != 2'h0 && o_mode != MODE_SLEEP) [*6]
    |-> o_mode == MODE_FAULT) else $error("overcurrent without fault mode");
  AST_UV_OFF: assert property (i_uv [*5] |-> o_chan_on == 2'h0)
    else $error("channel on during undervoltage");
  AST_FAULT_PIN: assert property ($rose(i_uv) && o_mode != MODE_SLEEP
    |-> ##[1:6] !o_fault_status_n) else $error("fault pin not low");
  AST_FS_PIN: assert property (o_mode == MODE_FAILSAFE [*3] |-> !o_failsafe_n)
    else $error("fail-safe pin high in fail-safe");
  AST_NORM_PIN: assert property (o_mode == MODE_NORMAL [*3] |-> o_failsafe_n)
    else $error("fail-safe pin low in normal mode");
  AST_BLOCK_RD: assert property (i_rd && o_mode inside {MODE_SLEEP, MODE_FAILSAFE}
    |=> o_rdata == 16'h0000) else $error("read not blocked");
endmodule // smfs_chk
bind smfs_top smfs_chk #(.WDOG_CYC(WDOG_CYC), .IDLE_CYC(IDLE_CYC)) chk_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wake_hold(i_wake_hold), .i_direct_in(i_direct_in),
  .i_oc(i_oc), .i_uv(i_uv), .i_rd(i_rd), .o_rdata(o_rdata), .o_chan_on(o_chan_on),
  .o_failsafe_n(o_failsafe_n), .o_fault_status_n(o_fault_status_n), .o_mode(o_mode));

// File: verif/smfs_host.sv
// host model: sends a serial word every 8 core clocks carrying the toggle bit
// assumes the bench chooses toggling or a fixed bit value
`timescale 1ns/1ps
module smfs_host (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tog,
  input  wire logic        i_fix,
  output logic             o_word_valid,
  output logic      [15:0] o_word
);
  logic [2:0] pace;
  logic       bit_q;
  wire        send     = (pace == 3'h7);
  wire        next_bit = i_tog ? ~bit_q : i_fix;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pace         <= 3'h0;
      bit_q        <= 1'b0;
      o_word_valid <= 1'b0;
      o_word       <= 16'h0000;
    end else begin
      pace         <= pace + 3'h1;
      o_word_valid <= send;
      // between words the data lines show a changing pattern, not the last word
      o_word       <= send ? {next_bit, 15'h0000} : ~o_word;
      if (send)
        bit_q <= next_bit;
    end
  end
endmodule // smfs_host

// File: verif/tb.sv
// self-checking bench for the mode and fault supervisor
// assumes short watchdog and idle counts; the host model supplies serial words
`timescale 1ns/1ps
module tb;
  import smfs_pkg::*;
  localparam int unsigned WD = 200;
  localparam int unsigned ID = 100;
  logic clk, rst_n, hold, vdd, tog, fix, rd, wr, ren, pon, wv, fs_n, flt_n;
  logic [1:0] din, ton, rrst, rexp, chan;
  logic [8:0] flt;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, word;
  smfs_mode_t mode;
  int failures, n_compared, seed;
  logic [15:0] mdl [int];
  smfs_top #(.WDOG_CYC(WD), .IDLE_CYC(ID)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_wake_hold(hold), .i_direct_in(din), .i_vdd_ok(vdd),
    .i_word_valid(wv), .i_word(word), .i_oc({1'b0, flt[0]}), .i_sc({1'b0, flt[1]}),
    .i_ot({1'b0, flt[2]}), .i_os({1'b0, flt[3]}), .i_ol_on({1'b0, flt[4]}),
    .i_ol_off({1'b0, flt[5]}), .i_clk_fail({1'b0, flt[6]}), .i_uv(flt[7]), .i_ov(flt[8]),
    .i_retry_turn_on(ton), .i_retry_expired(rexp), .i_retry_reset(rrst), .i_retry_en(ren),
    .i_power_on(pon), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_chan_on(chan), .o_failsafe_n(fs_n), .o_fault_status_n(flt_n),
    .o_mode(mode));
  smfs_host host_u (.i_clk(clk), .i_rst_n(rst_n), .i_tog(tog), .i_fix(fix),
    .o_word_valid(wv), .o_word(word));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cm(input smfs_mode_t m);
    chk("mode", 16'(m), 16'(mode));
  endtask
  task automatic mdl_reset();
    mdl[0] = GCR_RESET;
    mdl[3] = CFG_RESET;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    mdl[a] = d;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic wait_mode(input smfs_mode_t m, input int lim);
    int k;
    k = 0;
    while (mode !== m && k < lim) begin
      @(posedge clk);
      k++;
    end
    #1 cm(m);
    if (mode !== m)
      end_sim();
  endtask
  initial begin
    {rst_n, hold, vdd, tog, fix, rd, wr, pon, din, ton, rrst, rexp, flt} = '0;
    ren = 1'b1; addr = 4'h0; wdata = 16'h0000;
    failures = 0; n_compared = 0;
    seed = $urandom(32'h675969f9);
    mdl_reset();
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1 cm(MODE_SLEEP);
    chk("fs_n", 16'h0001, 16'(fs_n));
    rd_reg(REG_GLOBAL_CONFIG, 16'h0000);
    $display("test sleep done");
    @(posedge clk);
    vdd <= 1'b1; tog <= 1'b1; hold <= 1'b1;
    wait_mode(MODE_NORMAL, 20);
    rd_reg(REG_GLOBAL_CONFIG, mdl[0]);
    rd_reg(REG_CHAN_CFG, mdl[3]);
    rd_reg(4'hF, 16'h0000);
    wr_reg(REG_CHAN_CFG, 16'($urandom) & 16'h00F3);
    rd_reg(REG_CHAN_CFG, mdl[3]);
    $display("test registers done");
    tog <= 1'b0;
    wait_mode(MODE_FAILSAFE, WD + 64);
    chk("fs_n", 16'h0000, 16'(fs_n));
    rd_reg(REG_CHAN_CFG, 16'h0000);
    din <= 2'($urandom);
    repeat (6) @(posedge clk);
    chk("chan", 16'(din), 16'(chan));
    fix <= 1'b1;
    wait_mode(MODE_NORMAL, WD);
    tog <= 1'b1;
    mdl_reset();
    repeat (3) @(posedge clk);
    chk("fs_n", 16'h0001, 16'(fs_n));
    rd_reg(REG_CHAN_CFG, mdl[3]);
    $display("test failsafe done");
    wr_reg(REG_GLOBAL_CONFIG, mdl[0] | 16'h0010);
    tog <= 1'b0;
    repeat (2 * WD) @(posedge clk);
    cm(MODE_NORMAL);
    tog <= 1'b1;
    repeat (20) @(posedge clk);
    wr_reg(REG_GLOBAL_CONFIG, GCR_RESET);
    $display("test watchdog disable done");
    din <= 2'h3;
    wr_reg(REG_PULSE_WIDTH0, 16'h0100);
    for (int k = 0; k < 9; k++) begin
      flt <= 9'h001 << k;
      repeat (8) @(posedge clk);
      cm((k inside {0, 1, 2, 7, 8}) ? MODE_FAULT : MODE_NORMAL);
      if (k inside {0, 1, 2, 7, 8})
        chk("flt_n", 16'h0000, 16'(flt_n));
      chk("chan0", (k inside {0, 1, 2, 7, 8}) ? 16'h0000 : 16'h0001, 16'(chan[0]));
      flt <= 9'h000;
      repeat (4) @(posedge clk);
      ton <= 2'h3;
      @(posedge clk);
      ton <= 2'h0;
      wait_mode(MODE_NORMAL, 40);
      if (k < 3)
        rd_reg(REG_CHAN_FAULT0, 16'h0001 << k);
      if (k < 3)
        rd_reg(REG_CHAN_FAULT0, 16'h0000);
    end
    $display("test faults done");
    hold <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      din <= (j % 2 == 0) ? 2'h0 : 2'h3;
      repeat (ID / 2) @(posedge clk);
      chk("chan", 16'(din), 16'(chan));
    end
    cm(MODE_NORMAL);
    din <= 2'h0;
    wait_mode(MODE_SLEEP, ID + 40);
    repeat (20) @(posedge clk);
    chk("chan", 16'h0000, 16'(chan));
    $display("test sleep entry done");
    end_sim();
  end
endmodule // tb
